//--- cfg_pkg.sv
// Constants and types shared by the configuration front end
package cfg_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Quarter of a 100 kHz SMBus bit; least time, so round up
    localparam int SMB_QUARTER_NS = 2500;
    localparam logic [7:0] SMB_QUARTER_CYC =
        8'((SMB_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Cycles after reset release before straps are taken
    localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;
    localparam logic [6:0] SLAVE_BASE_ADDR = 7'h18;
    localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;
    localparam logic [7:0] CFG_LOAD_BYTES = 8'h10;
    localparam int STRAP_W = 4;
    localparam int SYNC_W = 8;
    localparam int SYNC_MODE = 0;
    localparam int SYNC_REQ = 1;
    localparam int SYNC_STRAP = 2;
    localparam int SYNC_SDA = 6;
    localparam int SYNC_SCL = 7;
    localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 8'hFF;

    typedef enum logic [2:0] {
        ST_STRAP, ST_WAIT_REQ, ST_M_START, ST_M_SEND,
        ST_M_RECV, ST_M_STOP, ST_SLAVE
    } top_st_t;

    typedef enum logic [2:0] {
        SL_IDLE, SL_ADDR, SL_PTR, SL_WDATA, SL_RDATA
    } sl_st_t;
endpackage : cfg_pkg

//--- bit_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : bit_sync

//--- smbus_config_loader.sv
// Power-up mode and address strap capture, EEPROM loader, SMBus slave
`timescale 1ns/1ps
module smbus_config_loader
    import cfg_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic config_source_select_pin,
    input wire logic load_request_n,
    output logic load_complete_n,
    input wire logic [STRAP_W-1:0] strap_lock_in,
    output logic [STRAP_W-1:0] strap_lock_out,
    output logic [STRAP_W-1:0] strap_lock_oe_n,
    input wire logic [STRAP_W-1:0] channel_lock,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic serial_bus_clock_pin_in,
    output logic serial_bus_clock_pin_out,
    output logic serial_bus_clock_pin_oe_n,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    logic [SYNC_W-1:0] sync_out;
    logic mode_s, req_n_s, sda_s, scl_s, sda_d, scl_d;
    logic [STRAP_W-1:0] strap_s;
    top_st_t state;
    sl_st_t sl_state;
    logic [2:0] settle;
    logic slave_mode, test_addr;
    logic [6:0] my_addr;
    logic [7:0] qcnt, mtx, byte_cnt, srx, stx, ptr;
    logic [1:0] phase;
    logic [3:0] bitn, sbit;
    logic m_scl_low, m_sda_low, s_sda_low;
    logic tick, master_st, scl_rise, scl_fall, bus_start, bus_stop;
    logic m_got, s_got, last_byte, m_bit_low;

    bit_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET_VAL)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .d({serial_bus_clock_pin_in, sda_in, strap_lock_in,
            load_request_n, config_source_select_pin}),
        .q(sync_out)
    );

    assign mode_s = sync_out[SYNC_MODE];
    assign req_n_s = sync_out[SYNC_REQ];
    assign strap_s = sync_out[SYNC_STRAP +: STRAP_W];
    assign sda_s = sync_out[SYNC_SDA];
    assign scl_s = sync_out[SYNC_SCL];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sda_d <= 1'b1;
            scl_d <= 1'b1;
        end else begin
            sda_d <= sda_s;
            scl_d <= scl_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // Straps are taken once, after the synchroniser has settled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            settle <= STRAP_SETTLE_CYC;
            slave_mode <= 1'b0;
            test_addr <= 1'b0;
            my_addr <= SLAVE_BASE_ADDR;
        end else if (state == ST_STRAP) begin
            if (settle != 3'h0) begin
                settle <= settle - 3'h1;
            end else begin
                slave_mode <= mode_s;
                test_addr <= mode_s & req_n_s;
                if (mode_s & req_n_s) begin
                    my_addr <= SLAVE_BASE_ADDR;
                end else begin
                    my_addr <= SLAVE_BASE_ADDR + {3'h0, strap_s};
                end
            end
        end
    end

    // Shared pins: inputs until sampled, then lock indication
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strap_lock_oe_n <= '1;
            strap_lock_out <= '0;
        end else if (state != ST_STRAP) begin
            strap_lock_oe_n <= '0;
            strap_lock_out <= channel_lock;
        end
    end

    assign master_st = (state == ST_M_START) || (state == ST_M_SEND) ||
                       (state == ST_M_RECV) || (state == ST_M_STOP);
    assign tick = master_st && (qcnt == 8'h00);
    assign last_byte = (byte_cnt == CFG_LOAD_BYTES - 8'h01);
    assign m_got = (state == ST_M_RECV) && tick && (phase == 2'h3) &&
                   (bitn == 4'h8);
    assign s_got = (state == ST_SLAVE) && (sl_state == SL_WDATA) &&
                   scl_fall && (sbit == 4'h7);
    // Master sends MSB first; ack low on all but the last byte read
    assign m_bit_low = (state == ST_M_SEND) ? ((bitn < 4'h8) & ~mtx[7]) :
                       ((bitn == 4'h8) & ~last_byte);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            qcnt <= SMB_QUARTER_CYC - 8'h01;
        end else if (!master_st || tick) begin
            qcnt <= SMB_QUARTER_CYC - 8'h01;
        end else begin
            qcnt <= qcnt - 8'h01;
        end
    end

    // Top sequence and EEPROM master; no clock stretching is honoured
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_STRAP;
            phase <= 2'h0;
            bitn <= 4'h0;
            mtx <= 8'h00;
            byte_cnt <= 8'h00;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            load_complete_n <= 1'b1;
        end else begin
            unique case (state)
                ST_STRAP: begin
                    if (settle == 3'h0) begin
                        state <= mode_s ? ST_SLAVE : ST_WAIT_REQ;
                    end
                end
                ST_WAIT_REQ: begin
                    if (!req_n_s) begin
                        state <= ST_M_START;
                        phase <= 2'h0;
                    end
                end
                ST_M_START: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            m_sda_low <= 1'b1;
                        end else begin
                            m_scl_low <= 1'b1;
                            state <= ST_M_SEND;
                            phase <= 2'h0;
                            bitn <= 4'h0;
                            mtx <= {EEPROM_DEV_ADDR, 1'b1};
                        end
                    end
                end
                ST_M_SEND, ST_M_RECV: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0: m_sda_low <= m_bit_low;
                            2'h1: m_scl_low <= 1'b0;
                            2'h2: begin
                                if (state == ST_M_RECV && bitn < 4'h8) begin
                                    mtx <= {mtx[6:0], sda_s};
                                end
                            end
                            2'h3: begin
                                m_scl_low <= 1'b1;
                                bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
                                if (state == ST_M_SEND && bitn < 4'h8) begin
                                    mtx <= {mtx[6:0], 1'b0};
                                end
                                // A refused address ends the load early
                                if (bitn == 4'h8 && state == ST_M_SEND) begin
                                    state <= sda_s ? ST_M_STOP : ST_M_RECV;
                                    byte_cnt <= 8'h00;
                                end else if (bitn == 4'h8) begin
                                    byte_cnt <= byte_cnt + 8'h01;
                                    if (last_byte) begin
                                        state <= ST_M_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_M_STOP: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0: m_sda_low <= 1'b1;
                            2'h1: m_scl_low <= 1'b0;
                            2'h2: m_sda_low <= 1'b0;
                            2'h3: begin
                                state <= ST_SLAVE;
                                load_complete_n <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_SLAVE: begin
                    m_scl_low <= 1'b0;
                    m_sda_low <= 1'b0;
                end
            endcase
        end
    end

    // SMBus slave: pointer byte, then writes or auto-incrementing reads
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sl_state <= SL_IDLE;
            sbit <= 4'h0;
            srx <= 8'h00;
            stx <= 8'h00;
            ptr <= 8'h00;
            s_sda_low <= 1'b0;
        end else if (state != ST_SLAVE) begin
            sl_state <= SL_IDLE;
            s_sda_low <= 1'b0;
        end else if (bus_start) begin
            sl_state <= SL_ADDR;
            // The clock fall that closes the start wraps this to 0
            sbit <= 4'hF;
            s_sda_low <= 1'b0;
        end else if (bus_stop) begin
            sl_state <= SL_IDLE;
            s_sda_low <= 1'b0;
        end else if (sl_state != SL_IDLE) begin
            if (scl_rise && sbit < 4'h8) begin
                srx <= {srx[6:0], sda_s};
            // Our own address ack must not count as a master ack
            end else if (scl_rise && sl_state == SL_RDATA && !s_sda_low) begin
                if (sda_s) begin
                    sl_state <= SL_IDLE;
                end else begin
                    ptr <= ptr + 8'h01;
                end
            end
            if (scl_fall && sbit == 4'h7) begin
                sbit <= 4'h8;
                unique case (sl_state)
                    SL_ADDR: begin
                        if (srx[7:1] == my_addr) begin
                            s_sda_low <= 1'b1;
                            sl_state <= srx[0] ? SL_RDATA : SL_PTR;
                        end else begin
                            sl_state <= SL_IDLE;
                        end
                    end
                    SL_PTR: begin
                        ptr <= srx;
                        s_sda_low <= 1'b1;
                        sl_state <= SL_WDATA;
                    end
                    SL_WDATA: begin
                        ptr <= ptr + 8'h01;
                        s_sda_low <= 1'b1;
                    end
                    SL_RDATA: s_sda_low <= 1'b0;
                    SL_IDLE: s_sda_low <= 1'b0;
                endcase
            end else if (scl_fall && sbit == 4'h8) begin
                sbit <= 4'h0;
                if (sl_state == SL_RDATA) begin
                    stx <= {reg_rdata[6:0], 1'b0};
                    s_sda_low <= ~reg_rdata[7];
                end else begin
                    s_sda_low <= 1'b0;
                end
            end else if (scl_fall) begin
                sbit <= sbit + 4'h1;
                if (sl_state == SL_RDATA) begin
                    s_sda_low <= ~stx[7];
                    stx <= {stx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_wr <= 1'b0;
            reg_addr <= 8'h00;
            reg_wdata <= 8'h00;
        end else begin
            reg_wr <= m_got | s_got;
            if (m_got) begin
                reg_addr <= byte_cnt;
                reg_wdata <= mtx;
            end else begin
                reg_addr <= ptr;
                reg_wdata <= srx;
            end
        end
    end

    // Open-drain: data level is always low, only the enables move
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            serial_bus_clock_pin_out <= 1'b0;
            serial_bus_clock_pin_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            serial_bus_clock_pin_out <= 1'b0;
            sda_oe_n <= ~((master_st & m_sda_low) | s_sda_low);
            serial_bus_clock_pin_oe_n <= ~(master_st & m_scl_low);
        end
    end

    property p_mode;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_STRAP && settle == 3'h0) |=>
            (state == ($past(mode_s) ? ST_SLAVE : ST_WAIT_REQ));
    endproperty
    a_mode: assert property (p_mode) else $error("wrong mode entered");

    property p_wait_req;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_WAIT_REQ && req_n_s) |=> (state == ST_WAIT_REQ);
    endproperty
    a_wait_req: assert property (p_wait_req)
        else $error("load began without request");

    property p_done;
        @(posedge clock) disable iff (!reset_n)
        $fell(load_complete_n) |-> (state == ST_SLAVE) &&
            ($past(state) == ST_M_STOP) && !slave_mode;
    endproperty
    a_done: assert property (p_done) else $error("bad load complete");

    property p_master_only;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_SLAVE) ##1 (state == ST_SLAVE) |=>
            serial_bus_clock_pin_oe_n;
    endproperty
    a_master_only: assert property (p_master_only)
        else $error("clock pulled low after load");

    property p_held;
        @(posedge clock) disable iff (!reset_n)
        (state != ST_STRAP && $past(state) != ST_STRAP) |->
            ($stable(my_addr) && $stable(slave_mode));
    endproperty
    a_held: assert property (p_held) else $error("straps changed");

    property p_test_addr;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_SLAVE && test_addr) |->
            (slave_mode && my_addr == 7'h18);
    endproperty
    a_test_addr: assert property (p_test_addr)
        else $error("test address not used");

    property p_addr_map;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_STRAP && settle == 3'h0 && !(mode_s & req_n_s)) |=>
            (my_addr == 7'h18 + {3'h0, $past(strap_s)});
    endproperty
    a_addr_map: assert property (p_addr_map)
        else $error("address not base plus straps");

    property p_addr_ack;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_SLAVE && sl_state == SL_ADDR && scl_fall &&
            sbit == 4'h7 && !bus_start && !bus_stop &&
            srx[7:1] == my_addr) |=> ##1 !sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_lock_pins;
        @(posedge clock) disable iff (!reset_n)
        (state == ST_SLAVE) ##1 1'b1 |-> (strap_lock_oe_n == 4'h0) &&
            (strap_lock_out == $past(channel_lock));
    endproperty
    a_lock_pins: assert property (p_lock_pins)
        else $error("lock pins not driven");
endmodule : smbus_config_loader

//--- smbus_partner.sv
// SMBus host controller and configuration EEPROM model for the bench
`timescale 1ns/1ps
module smbus_partner
    import cfg_pkg::*;
(
    input wire logic clock,
    input wire logic sda,
    input wire logic scl,
    output logic host_sda_low,
    output logic host_scl_low,
    output logic eep_sda_low
);
    logic [7:0] eep_addr;
    logic more;
    int k;

    initial begin
        host_sda_low = 1'b0;
        host_scl_low = 1'b0;
        eep_sda_low = 1'b0;
    end

    // One bit: six system cycles low, two high, 160 ns in all
    task automatic bit_xfer(input logic b, output logic r);
        repeat (2) @(negedge clock);
        host_sda_low = !b;
        repeat (4) @(negedge clock);
        host_scl_low = 1'b0;
        repeat (2) @(negedge clock);
        r = sda;
        host_scl_low = 1'b1;
    endtask : bit_xfer

    // Waits long enough for a slave still holding its ack to let go
    task automatic start();
        host_sda_low = 1'b0;
        repeat (6) @(negedge clock);
        host_scl_low = 1'b0;
        repeat (4) @(negedge clock);
        host_sda_low = 1'b1;
        repeat (4) @(negedge clock);
        host_scl_low = 1'b1;
    endtask : start

    task automatic stop();
        host_sda_low = 1'b1;
        repeat (6) @(negedge clock);
        host_scl_low = 1'b0;
        repeat (4) @(negedge clock);
        host_sda_low = 1'b0;
        repeat (4) @(negedge clock);
    endtask : stop

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = !r;
    endtask : send_byte

    task automatic recv_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(!ack_it, r);
    endtask : recv_byte

    // EEPROM: current-address read, byte k holds k xor C3
    always begin
        @(negedge sda iff scl === 1'b1);
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            eep_addr[i] = sda;
        end
        if (eep_addr == {EEPROM_DEV_ADDR, 1'b1}) begin
            @(negedge scl);
            @(negedge clock);
            eep_sda_low = 1'b1;
            @(negedge scl);
            @(negedge clock);
            k = 0;
            more = 1'b1;
            while (more) begin
                for (int b = 7; b >= 0; b--) begin
                    eep_sda_low = !(((k[7:0] ^ 8'hC3) >> b) & 8'h01);
                    @(negedge scl);
                    @(negedge clock);
                end
                eep_sda_low = 1'b0;
                @(posedge scl);
                more = !sda;
                @(negedge scl);
                @(negedge clock);
                k++;
            end
        end
    end
endmodule : smbus_partner

//--- test_smbus_config_loader.sv
// Self-checking bench for the configuration front end
`timescale 1ns/1ps
module test_smbus_config_loader
    import cfg_pkg::*;
;
    logic clock, reset_n, config_source_select_pin, load_request_n;
    logic load_complete_n, sda_out, sda_oe_n, sda, scl, reg_wr;
    logic serial_bus_clock_pin_out, serial_bus_clock_pin_oe_n;
    logic [STRAP_W-1:0] strap_lock_in, strap_lock_out, strap_lock_oe_n;
    logic [STRAP_W-1:0] channel_lock, strap_drive;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic host_sda_low, host_scl_low, eep_sda_low;
    logic [7:0] wr_addr[32], wr_data[32];
    int nwr, scl_pulls, od_bad, cycles, failures, compares;

    // Open-drain wires with pull-ups; strap pins shared with lock outputs
    assign sda = (sda_oe_n | sda_out) & !host_sda_low & !eep_sda_low;
    assign scl = (serial_bus_clock_pin_oe_n | serial_bus_clock_pin_out)
        & !host_scl_low;
    assign strap_lock_in = (strap_lock_oe_n & strap_drive)
        | (~strap_lock_oe_n & strap_lock_out);
    assign reg_rdata = reg_addr ^ 8'h5A;

    smbus_config_loader u_dut (.clock(clock), .reset_n(reset_n),
        .config_source_select_pin(config_source_select_pin),
        .load_request_n(load_request_n), .load_complete_n(load_complete_n),
        .strap_lock_in(strap_lock_in), .strap_lock_out(strap_lock_out),
        .strap_lock_oe_n(strap_lock_oe_n), .channel_lock(channel_lock),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .serial_bus_clock_pin_in(scl),
        .serial_bus_clock_pin_out(serial_bus_clock_pin_out),
        .serial_bus_clock_pin_oe_n(serial_bus_clock_pin_oe_n),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    smbus_partner u_partner (.clock(clock), .sda(sda), .scl(scl),
        .host_sda_low(host_sda_low), .host_scl_low(host_scl_low),
        .eep_sda_low(eep_sda_low));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (serial_bus_clock_pin_oe_n === 1'b0) scl_pulls++;
        if (reset_n && (sda_out !== 1'b0 || serial_bus_clock_pin_out !== 1'b0))
            od_bad++;
        if (reg_wr === 1'b1 && nwr < 32) begin
            wr_addr[nwr] = reg_addr;
            wr_data[nwr] = reg_wdata;
            nwr++;
        end
        if (cycles == 95000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // Lock levels are the inverse of the straps so that the pins flip
    task automatic power_up(input logic sel, input logic req,
        input logic [3:0] straps);
        @(negedge clock);
        reset_n = 1'b0;
        config_source_select_pin = sel;
        load_request_n = req;
        strap_drive = straps;
        channel_lock = ~straps;
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check("strap oe before capture", 8'(strap_lock_oe_n), 8'h0F);
        repeat (6) @(negedge clock);
        check("strap oe after capture", 8'(strap_lock_oe_n), 8'h00);
        check("lock out", {4'h0, strap_lock_out}, {4'h0, ~straps});
        nwr = 0;
        scl_pulls = 0;
    endtask : power_up

    task automatic probe(input logic [7:0] a, output logic ack);
        u_partner.start();
        u_partner.send_byte(a, ack);
        u_partner.stop();
    endtask : probe

    task automatic t_slave_no_req();
        logic ack;
        power_up(1'b1, 1'b1, 4'hA);
        probe(8'h44, ack);
        check("strap address ack", {7'h0, ack}, 8'h00);
        probe(8'h30, ack);
        check("test address ack", {7'h0, ack}, 8'h01);
        check("slave load complete", {7'h0, load_complete_n}, 8'h01);
        check("slave clock pulls", 8'(scl_pulls), 8'h00);
    endtask : t_slave_no_req

    task automatic t_strap_sweep();
        logic ack;
        logic [7:0] exp;
        for (int s = 0; s < 16; s++) begin
            power_up(1'b1, 1'b0, 4'(s));
            exp = (8'h18 + 8'(s)) << 1;
            probe(exp, ack);
            check("own address ack", {7'h0, ack}, 8'h01);
            probe(exp ^ 8'h02, ack);
            check("other address ack", {7'h0, ack}, 8'h00);
        end
    endtask : t_strap_sweep

    task automatic t_write_read();
        logic a0, a1, a2, a3;
        logic [7:0] d;
        power_up(1'b1, 1'b0, 4'h3);
        u_partner.start();
        u_partner.send_byte(8'h36, a0);
        u_partner.send_byte(8'h05, a1);
        u_partner.send_byte(8'h3C, a2);
        u_partner.send_byte(8'hA7, a3);
        u_partner.stop();
        check("write acks", {4'h0, a0, a1, a2, a3}, 8'h0F);
        check("write count", 8'(nwr), 8'h02);
        check("write addr 0", wr_addr[0], 8'h05);
        check("write data 0", wr_data[0], 8'h3C);
        check("write addr 1", wr_addr[1], 8'h06);
        check("write data 1", wr_data[1], 8'hA7);
        u_partner.start();
        u_partner.send_byte(8'h36, a0);
        u_partner.send_byte(8'h10, a1);
        u_partner.start();
        u_partner.send_byte(8'h37, a2);
        check("read address ack", {7'h0, a2}, 8'h01);
        u_partner.recv_byte(1'b1, d);
        check("read byte 0", d, 8'h10 ^ 8'h5A);
        u_partner.recv_byte(1'b0, d);
        check("read byte 1", d, 8'h11 ^ 8'h5A);
        u_partner.stop();
    endtask : t_write_read

    task automatic t_master();
        logic ack;
        power_up(1'b0, 1'b1, 4'h5);
        repeat (600) @(negedge clock);
        check("idle clock pulls", 8'(scl_pulls), 8'h00);
        check("idle complete", {7'h0, load_complete_n}, 8'h01);
        load_request_n = 1'b0;
        for (int n = 0; n < 80000 && load_complete_n !== 1'b0; n++)
            @(negedge clock);
        check("load complete", {7'h0, load_complete_n}, 8'h00);
        check("load writes", 8'(nwr), 8'h10);
        for (int k = 0; k < 16; k++) begin
            check("load addr", wr_addr[k], 8'(k));
            check("load data", wr_data[k], 8'(k) ^ 8'hC3);
        end
        check("master drove clock", 8'(scl_pulls > 0), 8'h01);
        scl_pulls = 0;
        probe(8'h3A, ack);
        check("slave after load", {7'h0, ack}, 8'h01);
        check("no clock after load", 8'(scl_pulls), 8'h00);
        check("complete held", {7'h0, load_complete_n}, 8'h00);
    endtask : t_master

    initial begin
        reset_n = 1'b0;
        config_source_select_pin = 1'b1;
        load_request_n = 1'b0;
        strap_drive = 4'h0;
        channel_lock = 4'h0;
        t_slave_no_req();
        t_strap_sweep();
        t_write_read();
        t_master();
        check("open drain outputs", 8'(od_bad), 8'h00);
        give_verdict();
    end
endmodule : test_smbus_config_loader
